// ==== shared/mcc_pkg.sv ====
`default_nettype none
package mcc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_PRESCALE  = 8'h00;
    localparam logic [7:0] OFS_SWITCH    = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_MONITOR   = 8'h0C;
    localparam logic [7:0] OFS_GATE_ONE  = 8'h10;
    localparam logic [7:0] OFS_GATE_TWO  = 8'h14;
    localparam logic [7:0] OFS_CORE_GATE = 8'h18;
    localparam logic [7:0] OFS_CLK_OUT   = 8'h1C;

    // Source encodings, one bit per oscillator
    localparam logic [3:0] SRC_INTERNAL_FAST_RC = 4'h1;
    localparam logic [3:0] SRC_EXTERNAL_FAST    = 4'h2;
    localparam logic [3:0] SRC_EXTERNAL_USER    = 4'h4;
    localparam logic [3:0] SRC_INTERNAL_SLOW_RC = 4'h8;
    localparam logic [3:0] SRC_EXTERNAL_MASK    = 4'h6;

    // Reset values
    localparam logic [2:0] RST_PRESCALE  = 3'h3;
    localparam logic [7:0] RST_GATE_ONE  = 8'hDB;
    localparam logic [7:0] RST_GATE_TWO  = 8'h0C;
    localparam logic [1:0] RST_CORE_GATE = 2'h3;

    // Writable gate bits, reserved bits read zero
    localparam logic [7:0] MASK_GATE_ONE = 8'hDB;
    localparam logic [7:0] MASK_GATE_TWO = 8'h0C;

    // Gate bit positions
    localparam int ADVANCED_TIMER_GATE_BIT = 7;
    localparam int PWM_TIMER_GATE_BIT      = 6;
    localparam int BASIC_TIMER_GATE_BIT    = 4;
    localparam int UART_GATE_BIT           = 3;
    localparam int SPI_GATE_BIT            = 1;
    localparam int I2C_GATE_BIT            = 0;
    localparam int CONVERTER_GATE_BIT      = 3;
    localparam int WAKEUP_GATE_BIT         = 2;

    // Status and control field positions
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_FAIL_BIT = 9;
    localparam int MON_EN_BIT    = 0;
    localparam int MON_IRQ_BIT   = 1;

    // Failure timeout
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAIL_TIME_NS  = 2000;
    localparam int FAIL_CYCLES   = FAIL_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } mcc_pgate_t;

    typedef enum logic [1:0] {
        MCC_OUT_MASTER = 2'h0,
        MCC_OUT_CPU    = 2'h1,
        MCC_OUT_SLOW   = 2'h2,
        MCC_OUT_FAST   = 2'h3
    } mcc_outsel_t;

    typedef enum logic [1:0] {
        MCC_RUN    = 2'b01,
        MCC_SWITCH = 2'b10
    } mcc_state_t;

endpackage
`default_nettype wire

// ==== verilog/mcc_master_clock_controller.sv ====
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mcc_master_clock_controller
#(
    parameter int FAIL_LIMIT = mcc_pkg::FAIL_CYCLES
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0]        src_tick,
    input  wire logic [3:0]        src_ready,
    output logic                   master_clk_en,
    output logic                   core_clk_en,
    output logic                   mem_clk_en,
    output mcc_pkg::mcc_pgate_t    periph_clk_en,
    output logic                   clock_output_pin,
    output logic                   clock_fail_irq,
    output logic [3:0]             active_source
);
    import mcc_pkg::*;

    logic [2:0]  div_ff;
    logic [3:0]  active_ff;
    logic [3:0]  target_ff;
    mcc_state_t  state_ff;
    logic        mon_en_ff;
    logic        mon_irq_ff;
    logic        fail_flag_ff;
    mcc_pgate_t  gate_ff;
    logic [1:0]  core_gate_ff;
    logic        cco_en_ff;
    mcc_outsel_t cco_sel_ff;
    logic [6:0]  cnt_ff;
    logic [15:0] gap_ff;
    logic        master_ff;
    logic        cpu_ff;
    logic        core_ff;
    logic        mem_ff;
    mcc_pgate_t  periph_ff;
    logic        cco_ff;
    logic        irq_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    logic        wr_take;
    logic        rd_set;
    logic        mapped;
    logic [31:0] nxt_rdata;
    logic [3:0]  watch;
    logic        fail_now;
    logic        old_tick;
    logic        new_ready;
    logic        sw_write;
    logic        master_tick;
    logic [6:0]  limit;
    logic        cpu_tick;
    logic        cco_src;

    // Bus access phases
    assign wr_take = psel & penable & pready_ff & pwrite;
    assign rd_set  = psel & penable & ~pready_ff;
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= OFS_CLK_OUT);
    assign sw_write = wr_take && paddr == OFS_SWITCH &&
                      $onehot(pwdata[3:0]);

    // Read mux
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (paddr == OFS_PRESCALE)
            nxt_rdata[2:0] = div_ff;
        else if (paddr == OFS_SWITCH)
            nxt_rdata[3:0] = target_ff;
        else if (paddr == OFS_STATUS)
        begin
            nxt_rdata[3:0] = active_ff;
            nxt_rdata[7:4] = src_ready;
            nxt_rdata[STAT_BUSY_BIT] = (state_ff == MCC_SWITCH);
            nxt_rdata[STAT_FAIL_BIT] = fail_flag_ff;
        end
        else if (paddr == OFS_MONITOR)
            nxt_rdata[1:0] = {mon_irq_ff, mon_en_ff};
        else if (paddr == OFS_GATE_ONE)
            nxt_rdata[7:0] = gate_ff.one;
        else if (paddr == OFS_GATE_TWO)
            nxt_rdata[7:0] = gate_ff.two;
        else if (paddr == OFS_CORE_GATE)
            nxt_rdata[1:0] = core_gate_ff;
        else if (paddr == OFS_CLK_OUT)
            nxt_rdata[2:0] = {cco_sel_ff, cco_en_ff};
    end

    // Bus slave, one wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= rd_set;
            pslverr_ff <= rd_set & ~mapped;
            if (rd_set && !pwrite)
                prdata_ff <= nxt_rdata;
        end
    end

    // Failure monitor watches the external source in use or targeted
    assign watch = (active_ff | ((state_ff == MCC_SWITCH) ? target_ff
                   : 4'h0)) & SRC_EXTERNAL_MASK;
    assign fail_now = mon_en_ff && (|watch) &&
                      gap_ff >= 16'(FAIL_LIMIT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_ff <= 16'h0000;
        else if (!(|watch) || (|(src_tick & watch)) || fail_now)
            gap_ff <= 16'h0000;
        else if (gap_ff != 16'hFFFF)
            gap_ff <= gap_ff + 16'h0001;
    end

    // Monitor enable is set-only until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mon_en_ff  <= 1'b0;
            mon_irq_ff <= 1'b0;
        end
        else if (wr_take && paddr == OFS_MONITOR)
        begin
            mon_en_ff  <= mon_en_ff | pwdata[MON_EN_BIT];
            mon_irq_ff <= pwdata[MON_IRQ_BIT];
        end
    end

    // Sticky failure flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fail_flag_ff <= 1'b0;
        else if (fail_now)
            fail_flag_ff <= 1'b1;
        else if (wr_take && paddr == OFS_STATUS &&
                 pwdata[STAT_FAIL_BIT])
            fail_flag_ff <= 1'b0;
    end

    // Source switch: old source kept until new one ready
    assign old_tick  = |(src_tick & active_ff);
    assign new_ready = |(src_ready & target_ff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_ff <= SRC_INTERNAL_FAST_RC;
            target_ff <= SRC_INTERNAL_FAST_RC;
            state_ff  <= MCC_RUN;
        end
        else if (fail_now)
        begin
            active_ff <= SRC_INTERNAL_FAST_RC;
            target_ff <= SRC_INTERNAL_FAST_RC;
            state_ff  <= MCC_RUN;
        end
        else if (sw_write)
        begin
            target_ff <= pwdata[3:0];
            state_ff  <= (pwdata[3:0] == active_ff) ? MCC_RUN : MCC_SWITCH;
        end
        else
        begin
            case (state_ff)
                MCC_RUN:
                    state_ff <= MCC_RUN;
                MCC_SWITCH:
                    if (new_ready && old_tick)
                    begin
                        active_ff <= target_ff;
                        state_ff  <= MCC_RUN;
                    end
                default:
                    state_ff <= MCC_RUN;
            endcase
        end
    end

    // Prescaler ratio, two to the power of the field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_ff <= RST_PRESCALE;
        else if (fail_now)
            div_ff <= RST_PRESCALE;
        else if (wr_take && paddr == OFS_PRESCALE)
            div_ff <= pwdata[2:0];
    end

    assign master_tick = old_tick;
    assign limit       = ~(7'h7F << div_ff);
    assign cpu_tick    = master_tick && (cnt_ff >= limit);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= 7'h00;
        else if (master_tick)
            cnt_ff <= (cnt_ff >= limit) ? 7'h00 : cnt_ff + 7'h01;
    end

    // Gate registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_ff.one  <= RST_GATE_ONE;
            gate_ff.two  <= RST_GATE_TWO;
            core_gate_ff <= RST_CORE_GATE;
            cco_en_ff    <= 1'b0;
            cco_sel_ff   <= MCC_OUT_MASTER;
        end
        else if (wr_take)
        begin
            if (paddr == OFS_GATE_ONE)
                gate_ff.one <= pwdata[7:0] & MASK_GATE_ONE;
            else if (paddr == OFS_GATE_TWO)
                gate_ff.two <= pwdata[7:0] & MASK_GATE_TWO;
            else if (paddr == OFS_CORE_GATE)
                core_gate_ff <= pwdata[1:0];
            else if (paddr == OFS_CLK_OUT)
            begin
                cco_en_ff  <= pwdata[0];
                cco_sel_ff <= mcc_outsel_t'(pwdata[2:1]);
            end
        end
    end

    // Clock output source
    always_comb
    begin
        case (cco_sel_ff)
            MCC_OUT_MASTER: cco_src = master_tick;
            MCC_OUT_CPU:    cco_src = cpu_tick;
            MCC_OUT_SLOW:   cco_src = src_tick[3];
            default:        cco_src = src_tick[0];
        endcase
    end

    // Gated clock enables and pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            master_ff <= 1'b0;
            cpu_ff    <= 1'b0;
            core_ff   <= 1'b0;
            mem_ff    <= 1'b0;
            periph_ff <= '0;
            cco_ff    <= 1'b0;
            irq_ff    <= 1'b0;
        end
        else
        begin
            master_ff     <= master_tick;
            cpu_ff        <= cpu_tick;
            core_ff       <= cpu_tick & core_gate_ff[0];
            mem_ff        <= cpu_tick & core_gate_ff[1];
            periph_ff.one <= {8{cpu_tick}} & gate_ff.one;
            periph_ff.two <= {8{cpu_tick}} & gate_ff.two;
            if (!cco_en_ff)
                cco_ff <= 1'b0;
            else if (cco_src)
                cco_ff <= ~cco_ff;
            irq_ff <= fail_flag_ff & mon_irq_ff;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign master_clk_en    = master_ff;
    assign core_clk_en      = core_ff;
    assign mem_clk_en       = mem_ff;
    assign periph_clk_en    = periph_ff;
    assign clock_output_pin = cco_ff;
    assign clock_fail_irq   = irq_ff;
    assign active_source    = active_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    reset_source_a: assert property (
        $rose(presetn) |-> active_ff == SRC_INTERNAL_FAST_RC &&
        div_ff == RST_PRESCALE)
        else $error("Reset source is not internal RC over eight");
    hold_old_a: assert property (
        state_ff == MCC_SWITCH && !(new_ready && old_tick) && !fail_now &&
        !sw_write |=> $stable(active_ff))
        else $error("Source changed before new source ready");
    switch_done_a: assert property (
        state_ff == MCC_SWITCH && new_ready && old_tick && !fail_now &&
        !sw_write |=> active_ff == $past(target_ff) && state_ff == MCC_RUN)
        else $error("Switch did not complete");
    prescale_a: assert property (
        div_ff == 3'h0 && !fail_now |-> cpu_tick == master_tick)
        else $error("Prescaler one does not pass master tick");
    core_gate_a: assert property (
        !core_gate_ff[0] |=> !core_ff)
        else $error("Core clock not stopped");
    mon_sticky_a: assert property (
        mon_en_ff |=> mon_en_ff)
        else $error("Monitor enable dropped");
    fallback_a: assert property (
        fail_now |=> active_ff == SRC_INTERNAL_FAST_RC &&
        div_ff == RST_PRESCALE)
        else $error("Failure did not force fallback");
    fail_flag_a: assert property (
        fail_now |=> fail_flag_ff)
        else $error("Failure flag not set");
    fail_keep_a: assert property (
        fail_flag_ff && !(wr_take && paddr == OFS_STATUS &&
        pwdata[STAT_FAIL_BIT]) |=> fail_flag_ff)
        else $error("Failure flag dropped");
    gate_res_a: assert property (
        (gate_ff.one & ~MASK_GATE_ONE) == 8'h00 &&
        (gate_ff.two & ~MASK_GATE_TWO) == 8'h00)
        else $error("Reserved gate bit set");
    cco_off_a: assert property (
        !cco_en_ff |=> !cco_ff)
        else $error("Clock output not idle");
    irq_a: assert property (
        fail_flag_ff && mon_irq_ff |=> clock_fail_irq)
        else $error("Interrupt missing");

    switch_c: cover property (state_ff == MCC_SWITCH ##[1:100]
        state_ff == MCC_RUN);
    fail_c: cover property (fail_now);
    cco_c: cover property (cco_en_ff && $rose(cco_ff));

endmodule
`default_nettype wire

// ==== testbench/mcc_osc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcc_osc_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ext_on,
    input  wire logic        ext_stop,
    output logic [3:0]       src_tick,
    output logic [3:0]       src_ready
);
    logic [7:0] cnt_ff;
    logic       ext_run;

    assign ext_run = ext_on && !ext_stop;

    // Fast RC every 2, crystal every 3, user every 4, slow RC every 8
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff   <= 8'h00;
            src_tick <= 4'h0;
        end
        else
        begin
            cnt_ff      <= cnt_ff + 8'h01;
            src_tick[0] <= cnt_ff[0];
            src_tick[1] <= ext_run && ((cnt_ff % 8'h03) == 8'h00);
            src_tick[2] <= ext_run && (cnt_ff[1:0] == 2'h1);
            src_tick[3] <= (cnt_ff[2:0] == 3'h7);
        end
    end

    // External sources stable only once started
    assign src_ready = {1'b1, ext_on, ext_on, 1'b1};
endmodule
`default_nettype wire

// ==== testbench/tb_master_clock_controller.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_master_clock_controller;
    import mcc_pkg::*;
    localparam int LIM = 20;
    localparam logic [3:0] TGT [4] = '{4'h4, 4'h8, 4'h1, 4'h2};
    localparam int TOG [4] = '{32, 4, 8, 32};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  src_tick;
    logic [3:0]  src_ready;
    logic        master_clk_en;
    logic        core_clk_en;
    logic        mem_clk_en;
    mcc_pgate_t  periph_clk_en;
    logic        clock_output_pin;
    logic        clock_fail_irq;
    logic [3:0]  active_source;
    logic        ext_on;
    logic        ext_stop;
    logic [3:0]  tick_q;
    logic [3:0]  act_q;
    logic        pin_q;
    mcc_pgate_t  seen;
    logic [31:0] rd;
    logic        err;
    logic [31:0] v;
    int          fails;
    int          check_count;
    int          seed;
    int          n_mst;
    int          n_core;
    int          n_mem;
    int          n_pin;

    mcc_master_clock_controller #(.FAIL_LIMIT(LIM)) u_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_tick(src_tick), .src_ready(src_ready),
        .master_clk_en(master_clk_en), .core_clk_en(core_clk_en),
        .mem_clk_en(mem_clk_en), .periph_clk_en(periph_clk_en),
        .clock_output_pin(clock_output_pin),
        .clock_fail_irq(clock_fail_irq), .active_source(active_source)
    );

    mcc_osc_model u_osc
    (
        .pclk(pclk), .presetn(presetn), .ext_on(ext_on),
        .ext_stop(ext_stop), .src_tick(src_tick), .src_ready(src_ready)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic ratio_ok(input int m, input int c,
                                      input int d);
        return (c << d) + (1 << d) >= m && (c << d) <= m + (1 << d);
    endfunction

    function automatic logic near(input int e, input int g);
        return g >= e - 1 && g <= e + 1;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        chk("pready", 1'b1, pready);
        if (pready !== 1'b1)
            summarize();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask

    task automatic wait_src(input logic [3:0] s);
        int k;
        k = 0;
        while (active_source !== s && k < 300)
        begin
            @(posedge pclk);
            k++;
        end
        chk("active source", s, active_source);
        if (active_source !== s)
            summarize();
    endtask

    task automatic count(input int n);
        n_mst = 0;
        n_core = 0;
        n_mem = 0;
        n_pin = 0;
        seen = '0;
        pin_q = clock_output_pin;
        repeat (n)
        begin
            @(posedge pclk);
            n_mst += master_clk_en;
            n_core += core_clk_en;
            n_mem += mem_clk_en;
            n_pin += (clock_output_pin !== pin_q);
            pin_q = clock_output_pin;
            seen = seen | periph_clk_en;
        end
    endtask

    // Master tick only from a tick of the active or new source
    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && master_clk_en === 1'b1)
            chk("master tick", 1,
                |(tick_q & (act_q | active_source)));
        tick_q <= src_tick;
        act_q  <= active_source;
    end

    initial
    begin
        seed = 32'hb29d;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ext_on = 1'b0;
        ext_stop = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_PRESCALE, 32'h0000_0003, "prescale");
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("start source", SRC_INTERNAL_FAST_RC, rd[3:0]);
        rdc(OFS_GATE_ONE, 32'h0000_00db, "gate one");
        rdc(OFS_GATE_TWO, 32'h0000_000c, "gate two");
        rdc(OFS_MONITOR, 32'h0000_0000, "monitor");
        for (int i = 0; i < 6; i++)
        begin
            v = (i < 4) ? i : ($random(seed) & 3);
            wr(OFS_PRESCALE, v);
            count(96);
            chk("core ratio", 1, ratio_ok(n_mst, n_core, v));
            chk("mem ratio", 1, ratio_ok(n_mst, n_mem, v));
        end
        wr(OFS_PRESCALE, 32'h0000_0001);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 32'h0000_0000 : (i == 1) ? '1 : $random(seed);
            wr(OFS_GATE_ONE, v[7:0]);
            wr(OFS_GATE_TWO, v[15:8]);
            wr(OFS_CORE_GATE, v[17:16]);
            rdc(OFS_GATE_ONE, v[7:0] & MASK_GATE_ONE, "gate one");
            rdc(OFS_GATE_TWO, v[15:8] & MASK_GATE_TWO, "gate two");
            count(64);
            chk("gate one run", v[7:0] & MASK_GATE_ONE, seen.one);
            chk("gate two run", v[15:8] & MASK_GATE_TWO, seen.two);
            chk("core run", v[16], n_core > 0);
            chk("mem run", v[17], n_mem > 0);
        end
        wr(OFS_CORE_GATE, 32'h0000_0003);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 1'b1, err);
        apb(1'b1, 8'h02, 32'h0000_0002);
        chk("unaligned", 1'b1, err);
        wr(OFS_SWITCH, 32'h0000_0003);
        repeat (30) @(posedge pclk);
        chk("bad target", SRC_INTERNAL_FAST_RC, active_source);
        wr(OFS_SWITCH, SRC_EXTERNAL_FAST);
        repeat (40) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("held source", SRC_INTERNAL_FAST_RC, rd[3:0]);
        chk("busy", 1'b1, rd[STAT_BUSY_BIT]);
        ext_on <= 1'b1;
        wait_src(SRC_EXTERNAL_FAST);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_SWITCH, TGT[i]);
            wait_src(TGT[i]);
        end
        ext_stop <= 1'b1;
        repeat (3 * LIM) @(posedge pclk);
        chk("no monitor", SRC_EXTERNAL_FAST, active_source);
        ext_stop <= 1'b0;
        wr(OFS_MONITOR, 32'h0000_0003);
        wr(OFS_MONITOR, 32'h0000_0000);
        apb(1'b0, OFS_MONITOR, 32'h0000_0000);
        chk("monitor held", 1'b1, rd[MON_EN_BIT]);
        wr(OFS_MONITOR, 32'h0000_0003);
        wr(OFS_PRESCALE, 32'h0000_0000);
        ext_stop <= 1'b1;
        wait_src(SRC_INTERNAL_FAST_RC);
        rdc(OFS_PRESCALE, 32'h0000_0003, "fallback div");
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("fail flag", 1'b1, rd[STAT_FAIL_BIT]);
        chk("irq", 1'b1, clock_fail_irq);
        ext_stop <= 1'b0;
        wr(OFS_STATUS, 32'h0000_0200);
        repeat (2) @(posedge pclk);
        chk("irq clear", 1'b0, clock_fail_irq);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("flag clear", 1'b0, rd[STAT_FAIL_BIT]);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CLK_OUT, (s << 1) | 1);
            count(64);
            chk("out toggles", 1, near(TOG[s], n_pin));
        end
        wr(OFS_CLK_OUT, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        count(32);
        chk("out idle", 0, n_pin);
        chk("out low", 0, clock_output_pin);
        wr(OFS_SWITCH, SRC_INTERNAL_SLOW_RC);
        wait_src(SRC_INTERNAL_SLOW_RC);
        wr(OFS_PRESCALE, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset source", SRC_INTERNAL_FAST_RC, active_source);
        presetn <= 1'b1;
        rdc(OFS_PRESCALE, 32'h0000_0003, "prescale");
        count(64);
        chk("start rate", 1, near(32, n_mst));
        chk("start div", 1, ratio_ok(n_mst, n_core, 3));
        summarize();
    end
endmodule
`default_nettype wire
